// ### design/spm_pkg.sv
// package: register map and field layout of the six pin port mux
`default_nettype none
package spm_pkg;
	localparam logic [7:0] ADDR_PORT_PIN_DATA     = 8'h3C;
	localparam logic [7:0] ADDR_CLOCK_OUT_SELECT  = 8'h3D;
	localparam logic [7:0] ADDR_PIN_DIRECTION     = 8'h3E;
	localparam logic [7:0] ADDR_PIN_FUNCTION_SEL  = 8'h3F;
	localparam logic [7:0] ADDR_SERIAL_CHAN_ROUTE = 8'hF4;
	localparam int         PIN_COUNT              = 6;
	localparam int         CLOCK_BIT_POS          = 2;
	localparam int         ROUTE_BIT_POS          = 0;
	localparam logic [5:0] RESET_PINS             = 6'h00;
	localparam logic [7:0] RESET_BYTE             = 8'h00;
	localparam logic [5:0] RESET_IDLE_PINS        = 6'h3F;
	// pin mode code: {second function, function, direction}
	typedef enum logic [2:0] {
		MODE_IN       = 3'h0,
		MODE_OUT      = 3'h1,
		MODE_ALT_IN   = 3'h2,
		MODE_ALT_OUT  = 3'h3,
		MODE_CLK_OUT  = 3'h5
	} spm_mode_type;
endpackage
`default_nettype wire

// ### design/spm_port.sv
// six pin port with serial channel and clock output pin mux
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: six pins 0..5, each a software controlled input or output
// R2: reset clears direction, function and second function registers
// R3: reset clears serial channel route register; pins are plain inputs
// R4: alternate functions active only when a control bit is written one
// R5: pin 0 carries channel 0 transmit, open drain selectable
// R6: pin 1 feeds its level to channel 0 receive
// R7: pin 2 is channel 0 clear to send and serial clock, or clock out
// R8: pin 3 carries channel 1 transmit or fast serial data out
// R9: pin 4 feeds channel 1 receive or fast serial data in
// R10: pin 5 is channel 1 cts and clock, or fast serial clock out
// R11: mode is the three bit code of second function, function, direction
// R12: plain output on pins 0 and 3 is push pull only
// R13: data reads give pin levels for inputs; writes set the output latch
module spm_port (
	input  wire logic       clk,                     // 10 MHz system clock
	input  wire logic       srst,                    // sync reset, high
	input  wire logic [7:0] reg_addr,                // register address
	input  wire logic [7:0] reg_wdata,               // write data
	input  wire logic       reg_wr,                  // write strobe
	input  wire logic       reg_rd,                  // read strobe
	output logic      [7:0] reg_rdata,               // read data, next cycle
	input  wire logic [5:0] pin_in,                  // pin levels
	output logic      [5:0] pin_out,                 // pin drive levels
	output logic      [5:0] pin_oe_n,                // low: pin driven
	input  wire logic       chan0_transmit,          // channel 0 tx data
	output logic            chan0_receive,           // channel 0 rx data
	output logic            chan0_clear_to_send,     // channel 0 cts level
	input  wire logic       chan0_serial_clock_o,    // channel 0 clock out
	output logic            chan0_serial_clock_i,    // channel 0 clock in
	input  wire logic       chan1_transmit,          // channel 1 tx data
	output logic            chan1_receive,           // channel 1 rx data
	output logic            chan1_clear_to_send,     // channel 1 cts level
	input  wire logic       chan1_serial_clock_o,    // channel 1 clock out
	output logic            chan1_serial_clock_i,    // channel 1 clock in
	input  wire logic       fast_serial_out,         // fast channel data out
	output logic            fast_serial_in,          // fast channel data in
	input  wire logic       fast_serial_clock,       // fast channel clock out
	input  wire logic       internal_clock           // internal clock source
);
	logic [5:0] data_latch_reg;
	logic [5:0] data_latch_next;
	logic [5:0] pin_direction_reg;
	logic [5:0] pin_direction_next;
	logic [5:0] pin_function_reg;
	logic [5:0] pin_function_next;
	logic       pin_two_clock_bit_reg;
	logic       pin_two_clock_bit_next;
	logic       route_fast_reg;
	logic       route_fast_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [5:0] out_reg;
	logic [5:0] out_next;
	logic [5:0] oe_n_reg;
	logic [5:0] oe_n_next;
	logic [5:0] to_chan_reg;
	logic [5:0] to_chan_next;
	logic       chan1_rx_reg;
	logic       chan1_rx_next;
	logic       fast_in_reg;
	logic       fast_in_next;
	logic [5:0] clk2_vec;
	logic [5:0] alt_level;
	logic [5:0] alt_drive;
	logic [5:0] od_mode;
	logic [5:0] port_read;

	// address decode; one strobe per register, unmapped writes fall away
	// the direction, function and clock select registers are write only and read back as zero,
	// so software must keep its own copy of every such control it writes;
	// a read-modify-write on them would clear the other pins' settings
	// only the data register and the route register answer a read
	wire wr_data  = reg_wr && (reg_addr == spm_pkg::ADDR_PORT_PIN_DATA);
	wire wr_clk   = reg_wr && (reg_addr == spm_pkg::ADDR_CLOCK_OUT_SELECT);
	wire wr_dir   = reg_wr && (reg_addr == spm_pkg::ADDR_PIN_DIRECTION);
	wire wr_func  = reg_wr && (reg_addr == spm_pkg::ADDR_PIN_FUNCTION_SEL);
	wire wr_route = reg_wr && (reg_addr == spm_pkg::ADDR_SERIAL_CHAN_ROUTE);
	wire rd_data  = reg_rd && (reg_addr == spm_pkg::ADDR_PORT_PIN_DATA);
	wire rd_route = reg_rd && (reg_addr == spm_pkg::ADDR_SERIAL_CHAN_ROUTE);

	// register next values; write-only controls keep state between writes
	assign data_latch_next    = wr_data ? reg_wdata[5:0] : data_latch_reg;
	assign pin_direction_next = wr_dir ? reg_wdata[5:0] : pin_direction_reg;
	assign pin_function_next  = wr_func ? reg_wdata[5:0] : pin_function_reg;
	assign pin_two_clock_bit_next = wr_clk ?
		reg_wdata[spm_pkg::CLOCK_BIT_POS] : pin_two_clock_bit_reg;
	assign route_fast_next = wr_route ?
		reg_wdata[spm_pkg::ROUTE_BIT_POS] : route_fast_reg;

	// only pin 2 owns a second function bit
	assign clk2_vec = {3'h0, pin_two_clock_bit_reg, 2'h0};

	// per pin alternate output level; route picks channel 1 or fast channel
	assign alt_level[0] = chan0_transmit; // R5
	assign alt_level[1] = 1'b0;
	assign alt_level[2] = chan0_serial_clock_o; // R7
	assign alt_level[3] = route_fast_reg ? fast_serial_out
		: chan1_transmit; // R8
	assign alt_level[4] = 1'b0;
	assign alt_level[5] = route_fast_reg ? fast_serial_clock
		: chan1_serial_clock_o; // R10

	// with the fast route, the fast channel owns pin 3 and pin 5 outputs once the function bit is set
	assign alt_drive[0] = pin_direction_reg[0];
	assign alt_drive[1] = 1'b0;
	assign alt_drive[2] = pin_direction_reg[2];
	assign alt_drive[3] = route_fast_reg | pin_direction_reg[3];
	assign alt_drive[4] = 1'b0;
	assign alt_drive[5] = route_fast_reg | pin_direction_reg[5];

	// open drain transmit only on pins 0 and 3 with direction zero
	assign od_mode = {2'h0, ~route_fast_reg, 2'h0, 1'b1}; // R5 R8 R12

	// data register reads the pin for inputs and the latch for outputs
	assign port_read = (pin_in & ~pin_direction_reg)
		| (data_latch_reg & pin_direction_reg); // R13

	// per pin mode decode from the three control bits
	// code is {second function, function, direction}:
	// 000 plain input, output stage off
	// 001 plain output, push pull from the output latch
	// 010 alternate role; transmit pins drive low only (open drain)
	// 011 alternate role, driven; receive pins stay inputs
	// 101 pin 2 only: internal clock out
	// other codes are reserved and leave the pin undriven
	// a fast route takes pins 3 and 5 whatever the direction bit,
	// since the fast channel has no open drain option of its own
	// only pin 2 has a second function bit; the others see zero there
	genvar g;
	generate
		for (g = 0; g < spm_pkg::PIN_COUNT; g++) begin : g_pin
			spm_pkg::spm_mode_type mode;
			assign mode = spm_pkg::spm_mode_type'({clk2_vec[g],
				pin_function_reg[g], pin_direction_reg[g]}); // R11
			always_comb begin
				out_next[g]  = 1'b0;
				oe_n_next[g] = 1'b1;
				case (mode)
				spm_pkg::MODE_OUT: begin // R1 R12
					out_next[g]  = data_latch_reg[g];
					oe_n_next[g] = 1'b0;
				end
				spm_pkg::MODE_ALT_IN, spm_pkg::MODE_ALT_OUT: begin // R4
					if (od_mode[g] && !pin_direction_reg[g]) begin
						// open drain: drive only the low level
						out_next[g]  = 1'b0;
						oe_n_next[g] = alt_level[g];
					end else if (alt_drive[g]) begin
						out_next[g]  = alt_level[g];
						oe_n_next[g] = 1'b0;
					end
				end
				spm_pkg::MODE_CLK_OUT: begin // R7
					out_next[g]  = internal_clock;
					oe_n_next[g] = 1'b0;
				end
				default: begin
					out_next[g]  = 1'b0;
					oe_n_next[g] = 1'b1;
				end
				endcase
			end
			// channel inputs see the pin only while the function bit is set
			assign to_chan_next[g] = pin_function_reg[g] ? pin_in[g]
				: 1'b1; // R6 R9
		end
	endgenerate

	// read data: only the data and route registers read back
	assign rdata_next = rd_data ? {2'h0, port_read}
		: rd_route ? {7'h00, route_fast_reg} : spm_pkg::RESET_BYTE;

	// route gates pin 4 before the flop, so both receive outputs
	// leave from a flop; the unselected channel sees an idle high line
	// and so never takes a false start bit from the other channel
	assign chan1_rx_next = route_fast_reg ? 1'b1 : to_chan_next[4]; // R9
	assign fast_in_next  = route_fast_reg ? to_chan_next[4] : 1'b1; // R9

	// the flops below are split one per register on purpose:
	// each reset value sits beside the register it belongs to,
	// and every pin facing output leaves straight from a flop,
	// which costs one clock of latency from any source to its pin;
	// at 10 MHz that delay is far below any serial bit time,
	// so the serial channels do not notice it
	// the control registers reset to zero, leaving every pin an input
	// and no serial role selected until software writes a one

	// output latch, cleared so a later output mode starts low
	always_ff @(posedge clk) begin
		if (srst) begin
			data_latch_reg <= spm_pkg::RESET_PINS; // R13
		end else begin
			data_latch_reg <= data_latch_next;
		end
	end

	// direction bits
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_direction_reg <= spm_pkg::RESET_PINS; // R2
		end else begin
			pin_direction_reg <= pin_direction_next;
		end
	end

	// function bits
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_function_reg <= spm_pkg::RESET_PINS; // R2
		end else begin
			pin_function_reg <= pin_function_next;
		end
	end

	// second function bit of pin 2
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_two_clock_bit_reg <= 1'b0; // R2
		end else begin
			pin_two_clock_bit_reg <= pin_two_clock_bit_next;
		end
	end

	// route bit: channel 1 or fast channel on pins 3 to 5
	always_ff @(posedge clk) begin
		if (srst) begin
			route_fast_reg <= 1'b0; // R3
		end else begin
			route_fast_reg <= route_fast_next;
		end
	end

	// read data stands for one cycle, then falls back to zero
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_reg <= spm_pkg::RESET_BYTE;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// pin drive levels
	always_ff @(posedge clk) begin
		if (srst) begin
			out_reg <= spm_pkg::RESET_PINS;
		end else begin
			out_reg <= out_next;
		end
	end

	// pin output enables; all released during reset
	always_ff @(posedge clk) begin
		if (srst) begin
			oe_n_reg <= spm_pkg::RESET_IDLE_PINS; // R2 R3
		end else begin
			oe_n_reg <= oe_n_next;
		end
	end

	// pin levels toward the serial channels, idle high
	always_ff @(posedge clk) begin
		if (srst) begin
			to_chan_reg <= spm_pkg::RESET_IDLE_PINS;
		end else begin
			to_chan_reg <= to_chan_next;
		end
	end

	// channel 1 receive level
	always_ff @(posedge clk) begin
		if (srst) begin
			chan1_rx_reg <= 1'b1;
		end else begin
			chan1_rx_reg <= chan1_rx_next;
		end
	end

	// fast channel receive level
	always_ff @(posedge clk) begin
		if (srst) begin
			fast_in_reg <= 1'b1;
		end else begin
			fast_in_reg <= fast_in_next;
		end
	end

	// every top output leaves straight from a flop;
	// clear to send and serial clock in share one pin, so one flop,
	// and the channel itself decides which of the two it listens to
	assign reg_rdata            = rdata_reg;
	assign pin_out              = out_reg;
	assign pin_oe_n             = oe_n_reg;
	assign chan0_receive        = to_chan_reg[1]; // R6
	assign chan0_clear_to_send  = to_chan_reg[2]; // R7
	assign chan0_serial_clock_i = to_chan_reg[2]; // R7
	assign chan1_receive        = chan1_rx_reg; // R9
	assign fast_serial_in       = fast_in_reg; // R9
	assign chan1_clear_to_send  = to_chan_reg[5]; // R10
	assign chan1_serial_clock_i = to_chan_reg[5]; // R10
endmodule
`default_nettype wire

// ### testbench/spm_peer.sv
// far side devices sitting on the six port pins
`timescale 1ns/1ps
`default_nettype none
module spm_peer (
	input  wire logic [5:0] pin_out,  // drive
	input  wire logic [5:0] pin_oe_n, // low: driven
	input  wire logic [5:0] ext,      // far level
	output logic      [5:0] pin_in    // wire level
);
	// a driven pin wins; undriven pins show the far level
	assign pin_in = (pin_out & ~pin_oe_n) | (ext & pin_oe_n);
endmodule
`default_nettype wire

// ### testbench/spm_port_asserts.sv
// checker for pin modes and register reads of the port mux
`timescale 1ns/1ps
`default_nettype none
module spm_port_chk (
	input wire logic       clk,             // clock
	input wire logic       srst,            // reset
	input wire logic [7:0] reg_addr,        // address
	input wire logic [7:0] reg_wdata,       // wdata
	input wire logic       reg_wr,          // write
	input wire logic       reg_rd,          // read
	input wire logic [7:0] reg_rdata,       // rdata
	input wire logic [5:0] pin_in,          // levels
	input wire logic [5:0] pin_out,         // drive
	input wire logic [5:0] pin_oe_n,        // enables
	input wire logic       chan0_transmit,  // tx0
	input wire logic       chan1_receive,   // rx1
	input wire logic       fast_serial_out, // fast tx
	input wire logic       internal_clock   // clk src
);
	logic [5:0] dir_reg, fn_reg, lat_reg, out_m;
	logic       f2_reg, rt_reg;
	// shadow of the controls; pin checks need the mode
	always_ff @(posedge clk) begin
		if (srst) begin
			{dir_reg, fn_reg, lat_reg, f2_reg, rt_reg} <= '0;
		end else if (reg_wr) begin
			case (reg_addr)
			8'h3C: lat_reg <= reg_wdata[5:0];
			8'h3D: f2_reg <= reg_wdata[2];
			8'h3E: dir_reg <= reg_wdata[5:0];
			8'h3F: fn_reg <= reg_wdata[5:0];
			8'hF4: rt_reg <= reg_wdata[0];
			default: ;
			endcase
		end
	end
	// pins in plain output mode; pin 2 leaves it for clock out
	assign out_m = dir_reg & ~fn_reg & ~{3'h0, f2_reg, 2'h0};
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	a_reset_idle: assert property ($fell(srst) |-> pin_oe_n == 6'h3F)
		else $error("pins driven after reset");
	a_data_read: assert property (
		reg_rd && reg_addr == 8'h3C && $stable(pin_in)
		|=> reg_rdata == {2'h0, ($past(pin_in) & ~$past(dir_reg))
		| ($past(lat_reg) & $past(dir_reg))})
		else $error("data read wrong");
	a_push_pull: assert property (
		|out_m |=> (((pin_out ^ $past(lat_reg))
		| pin_oe_n) & $past(out_m)) == 6'h00)
		else $error("plain output wrong");
	a_tx0_drive: assert property (
		fn_reg[0] && dir_reg[0] |=>
		pin_out[0] == $past(chan0_transmit) && !pin_oe_n[0])
		else $error("tx0 drive wrong");
	a_tx0_open: assert property (
		fn_reg[0] && !dir_reg[0] |=>
		!pin_out[0] && pin_oe_n[0] == $past(chan0_transmit))
		else $error("tx0 open drain wrong");
	a_fast_out: assert property (
		rt_reg && fn_reg[3] |=>
		pin_out[3] == $past(fast_serial_out) && !pin_oe_n[3])
		else $error("fast out wrong");
	a_clk_out: assert property (
		f2_reg && !fn_reg[2] && dir_reg[2] |=>
		pin_out[2] == $past(internal_clock) && !pin_oe_n[2])
		else $error("clock out wrong");
	a_rx1_gate: assert property (
		fn_reg[4] && !rt_reg && $past(fn_reg[4])
		&& !$past(rt_reg) |-> chan1_receive == $past(pin_in[4]))
		else $error("rx1 level wrong");
	c_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
	c_fast: cover property (rt_reg && fn_reg[3]);
	c_clk: cover property (f2_reg && dir_reg[2]);
endmodule
bind spm_port spm_port_chk chk_u (
	.clk             (clk),
	.srst            (srst),
	.reg_addr        (reg_addr),
	.reg_wdata       (reg_wdata),
	.reg_wr          (reg_wr),
	.reg_rd          (reg_rd),
	.reg_rdata       (reg_rdata),
	.pin_in          (pin_in),
	.pin_out         (pin_out),
	.pin_oe_n        (pin_oe_n),
	.chan0_transmit  (chan0_transmit),
	.chan1_receive   (chan1_receive),
	.fast_serial_out (fast_serial_out),
	.internal_clock  (internal_clock)
);
`default_nettype wire

// ### testbench/spm_port_bench.sv
// bench for the six pin port mux
`timescale 1ns/1ps
`default_nettype none
module spm_port_bench;
	logic       clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [5:0] pin_in, pin_out, pin_oe_n, ext = 6'h00;
	logic [6:0] src = 7'h00;
	logic       chan0_receive, chan0_clear_to_send, chan0_serial_clock_i;
	logic       chan1_receive, chan1_clear_to_send, chan1_serial_clock_i;
	logic       fast_serial_in;
	int         num_errors = 0, comparisons = 0;
	// 10 MHz clock
	always #50 clk = ~clk;
	spm_port dut_u (
		.clk                  (clk),
		.srst                 (srst),
		.reg_addr             (reg_addr),
		.reg_wdata            (reg_wdata),
		.reg_wr               (reg_wr),
		.reg_rd               (reg_rd),
		.reg_rdata            (reg_rdata),
		.pin_in               (pin_in),
		.pin_out              (pin_out),
		.pin_oe_n             (pin_oe_n),
		.chan0_transmit       (src[0]),
		.chan0_receive        (chan0_receive),
		.chan0_clear_to_send  (chan0_clear_to_send),
		.chan0_serial_clock_o (src[3]),
		.chan0_serial_clock_i (chan0_serial_clock_i),
		.chan1_transmit       (src[1]),
		.chan1_receive        (chan1_receive),
		.chan1_clear_to_send  (chan1_clear_to_send),
		.chan1_serial_clock_o (src[4]),
		.chan1_serial_clock_i (chan1_serial_clock_i),
		.fast_serial_out      (src[2]),
		.fast_serial_in       (fast_serial_in),
		.fast_serial_clock    (src[5]),
		.internal_clock       (src[6])
	);
	spm_peer peer_u (
		.pin_out  (pin_out),
		.pin_oe_n (pin_oe_n),
		.ext      (ext),
		.pin_in   (pin_in)
	);
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	// pins settle one register stage behind sources, so wait two edges
	task automatic drv(logic [6:0] s, logic [5:0] e);
		@(posedge clk);
		src <= s;
		ext <= e;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(string n, logic [7:0] a, logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(n, e, reg_rdata);
	endtask
	task automatic rst;
		@(posedge clk);
		srst <= 1'b1;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
	endtask
	// after reset every pin is an input and controls read back zero
	task automatic t_reset;
		drv(7'h00, 6'h2D);
		chk("oe_n", 8'h3F, {2'h0, pin_oe_n});
		chk("rx0", 8'h01, {7'h00, chan0_receive});
		rd("pins", 8'h3C, 8'h2D);
		rd("sel", 8'h3D, 8'h00);
		rd("dir", 8'h3E, 8'h00);
		rd("fn", 8'h3F, 8'h00);
		rd("route", 8'hF4, 8'h00);
		rd("gap", 8'h55, 8'h00);
	endtask
	task automatic t_out;
		wr(8'h3C, 8'h2A);
		wr(8'h3E, 8'h3F);
		drv(7'h00, 6'h15);
		chk("out", 8'h2A, {2'h0, pin_out});
		chk("oe_n", 8'h00, {2'h0, pin_oe_n});
		wr(8'h3E, 8'h0F);
		rd("mix", 8'h3C, 8'h1A);
		wr(8'h3E, 8'h00);
	endtask
	// first open drain, then driven transmit on pins 0 and 3
	task automatic t_tx;
		wr(8'h3F, 8'h09);
		for (int i = 0; i < 4; i++) begin
			if (i == 2) wr(8'h3E, 8'h09);
			drv({5'h00, {2{i[0]}}}, 6'h00);
			chk("tx", i < 2 ? {4'h0, {2{i[0]}}, 2'h0} : {6'h00, {2{i[0]}}},
				{4'h0, pin_oe_n[3], pin_oe_n[0], pin_out[3], pin_out[0]});
		end
		wr(8'h3E, 8'h00);
	endtask
	// receive levels with the route on channel 1, then on the fast channel
	task automatic t_rx;
		wr(8'h3F, 8'h1A);
		for (int i = 0; i < 4; i++) begin
			if (i == 2) wr(8'hF4, 8'h01);
			drv({7{i[0]}}, {6{i[0]}});
			chk("rx", {3'h0, i < 2 ? {i[0], 1'b0} : {1'b0, i[0]}, i[0],
				i < 2 ? {i[0], 1'b1} : {1'b1, i[0]}}, {3'h0, pin_oe_n[3],
				pin_out[3], chan0_receive, chan1_receive, fast_serial_in});
		end
		rd("route", 8'hF4, 8'h01);
	endtask
	task automatic t_clk;
		wr(8'h3F, 8'h20);
		wr(8'h3D, 8'h04);
		wr(8'h3E, 8'h04);
		for (int i = 0; i < 2; i++) begin
			drv({{2{i[0]}}, 5'h00}, 6'h00);
			chk("clk", {6'h00, {2{i[0]}}}, {6'h00, pin_out[5], pin_out[2]});
			chk("cts", {4'h0, 2'h3, {2{i[0]}}}, {4'h0, chan0_clear_to_send,
				chan0_serial_clock_i, chan1_clear_to_send,
				chan1_serial_clock_i});
		end
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// main sequence, with a second reset in mid run
	initial begin
		rst;
		t_reset;
		t_out;
		t_tx;
		t_rx;
		t_clk;
		rst;
		t_reset;
		tally_and_finish;
	end
endmodule
`default_nettype wire
